// ---- pkg/pbc_pkg.sv ----
// Purpose: shared constants for the push button power controller
// Assumes: 10 MHz system clock, millisecond timebase derived inside the block
// Notes: times stay in ms here; only TICK_CYCLES gives the clocks per ms tick
package pbc_pkg;
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / MS_PER_S;
  localparam int unsigned TICK_W = 14;
  localparam int unsigned MS_W = 16;
  localparam logic [MS_W-1:0] TURN_ON_DEBOUNCE_MS = 16'h0020;
  localparam logic [MS_W-1:0] TURN_OFF_DEBOUNCE_MS = 16'h0020;
  localparam logic [MS_W-1:0] KEEP_ALIVE_BLANK_MS = 16'h0200;
  localparam logic [MS_W-1:0] FORCED_OFF_BASE_MS = 16'h0040;
  localparam logic [MS_W-1:0] FORCED_OFF_EXTRA_MS_DEF = 16'h0000;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
  localparam int unsigned SYNC_W = 4;
  localparam int unsigned SYNC_PB = 0;
  localparam int unsigned SYNC_UV = 1;
  localparam int unsigned SYNC_WARN = 2;
  localparam int unsigned SYNC_KEEP = 3;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 4'hf;
endpackage

// ---- logic/pbc_sync.sv ----
// Purpose: two-flop synchronisers for the slow external inputs
// Assumes: inputs idle high, so flops reset to one
// Notes: only the second stage is visible outside
`timescale 1ns/100ps
module pbc_sync
  import pbc_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [SYNC_W-1:0] i_async,
  output logic [SYNC_W-1:0] o_sync
);
  logic [SYNC_W-1:0] stage1;
  logic [SYNC_W-1:0] next_stage1;
  logic [SYNC_W-1:0] next_sync;

  always_comb
  begin
    next_stage1 = i_async;
    next_sync = stage1;
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      stage1 <= SYNC_RESET;
      o_sync <= SYNC_RESET;
    end
    else
    begin
      stage1 <= next_stage1;
      o_sync <= next_sync;
    end
  end
endmodule

// ---- logic/pbc_ctrl.sv ----
// Purpose: push button on/off controller with host keep-alive handshake
// Assumes: comparator results arrive as digital levels, low meaning below threshold
// Notes: extra power-down delay is a parameter in ms instead of a capacitor
//
// Summary of operation
// - enable asserts only after the button is low without a break for 32 ms.
// - assertion of enable starts a 512 ms blanking window that ignores keep-alive.
// - keep-alive still low at the end of blanking drops enable at once.
// - only a debounced button press can turn power on.
// - after blanking, the interrupt goes low once button or undervoltage is low for 32 ms.
// - the first power-down source to go low owns the sequence; the other is ignored.
// - the owner held low for 64 ms plus the extra delay forces enable off.
// - keep-alive low after blanking drops enable during normal operation.
// - the warning output follows the warning comparator three clocks later, with no gating.
// - while off and undervoltage is low, button activity is ignored.
// - enable polarity is selectable with identical sequencing.
// - interrupt stays low at least 32 ms, while the owning source is held, and drops with enable.
// - with no extra delay programmed the forced-off delay is 64 ms.
`timescale 1ns/100ps
module pbc_ctrl
  import pbc_pkg::*;
#(
  parameter logic [MS_W-1:0] POWER_DOWN_EXTRA_DELAY = FORCED_OFF_EXTRA_MS_DEF,
  parameter bit ENABLE_ACTIVE_HIGH = 1'b1,
  // clocks per millisecond tick; a bench may shorten it to keep runs small
  parameter int unsigned TICK_LEN = TICK_CYCLES
)
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_push_button_n,
  input wire logic i_undervoltage_lockout,
  input wire logic i_supply_warn_in,
  input wire logic i_keep_alive,
  output logic o_power_enable,
  output logic o_interrupt_n,
  output logic o_supply_warn_out_n,
  output logic o_supply_warn_out_oe
);
  typedef enum logic [2:0] {ST_OFF, ST_BLANK, ST_ON, ST_DOWN} state_t;
  typedef enum logic [1:0] {OWN_NONE, OWN_PB, OWN_UV} owner_t;

  logic [SYNC_W-1:0] syn;
  logic pb_low;
  logic uv_low;
  logic warn_low;
  logic keep_high;

  pbc_sync u_sync
  (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_async({i_keep_alive, i_supply_warn_in, i_undervoltage_lockout, i_push_button_n}),
    .o_sync(syn)
  );

  assign pb_low = ~syn[SYNC_PB];
  assign uv_low = ~syn[SYNC_UV];
  assign warn_low = ~syn[SYNC_WARN];
  assign keep_high = syn[SYNC_KEEP];

  // millisecond timebase
  logic [TICK_W-1:0] tick_cnt;
  logic [TICK_W-1:0] next_tick_cnt;
  logic tick;
  logic next_tick;
  localparam logic [TICK_W-1:0] TICK_END = TICK_W'(TICK_LEN - 1);

  always_comb
  begin
    next_tick = (tick_cnt == TICK_END);
    next_tick_cnt = next_tick ? '0 : tick_cnt + 1'b1;
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end
    else
    begin
      tick_cnt <= next_tick_cnt;
      tick <= next_tick;
    end
  end

  function automatic logic [MS_W-1:0] ms_step(input logic [MS_W-1:0] cnt, input logic t);
    ms_step = (t && cnt != '1) ? cnt + 1'b1 : cnt;
  endfunction

  localparam logic [MS_W-1:0] FORCED_OFF_MS = MS_W'(FORCED_OFF_BASE_MS + POWER_DOWN_EXTRA_DELAY);

  state_t state;
  state_t next_state;
  owner_t owner;
  owner_t next_owner;
  logic [MS_W-1:0] deb_ms;
  logic [MS_W-1:0] next_deb_ms;
  logic [MS_W-1:0] phase_ms;
  logic [MS_W-1:0] next_phase_ms;
  logic en_on;
  logic next_en_on;
  logic int_low;
  logic next_int_low;
  logic owner_low;

  always_comb
  begin
    next_state = state;
    next_owner = owner;
    next_deb_ms = deb_ms;
    next_phase_ms = phase_ms;
    next_en_on = en_on;
    next_int_low = int_low;
    owner_low = (owner == OWN_PB) ? pb_low : (owner == OWN_UV) ? uv_low : 1'b0;
    unique case (state)
      ST_OFF:
      begin
        next_int_low = 1'b0;
        next_owner = OWN_NONE;
        // lockout: a dead supply cannot be powered by the button
        if (!pb_low || uv_low)
          next_deb_ms = '0;
        else
          next_deb_ms = ms_step(deb_ms, tick);
        if (deb_ms >= TURN_ON_DEBOUNCE_MS)
        begin
          next_state = ST_BLANK;
          next_en_on = 1'b1;
          next_phase_ms = '0;
          next_deb_ms = '0;
        end
      end
      ST_BLANK:
      begin
        next_phase_ms = ms_step(phase_ms, tick);
        if (phase_ms >= KEEP_ALIVE_BLANK_MS)
        begin
          if (keep_high)
            next_state = ST_ON;
          else
          begin
            next_state = ST_OFF;
            next_en_on = 1'b0;
          end
        end
      end
      ST_ON:
      begin
        if (!keep_high)
        begin
          next_state = ST_OFF;
          next_en_on = 1'b0;
          next_int_low = 1'b0;
        end
        else if (pb_low || uv_low)
        begin
          // the first low source takes ownership; button wins a tie
          next_owner = pb_low ? OWN_PB : OWN_UV;
          next_state = ST_DOWN;
          next_phase_ms = '0;
        end
      end
      ST_DOWN:
      begin
        next_phase_ms = ms_step(phase_ms, tick);
        if (!keep_high)
        begin
          next_state = ST_OFF;
          next_en_on = 1'b0;
          next_int_low = 1'b0;
        end
        else if (owner_low && phase_ms >= FORCED_OFF_MS)
        begin
          next_state = ST_OFF;
          next_en_on = 1'b0;
          next_int_low = 1'b0;
        end
        else if (owner_low && phase_ms >= TURN_OFF_DEBOUNCE_MS)
          next_int_low = 1'b1;
        else if (!owner_low)
        begin
          if (!int_low)
          begin
            // released before the debounce time: no interrupt, drop ownership
            next_state = ST_ON;
            next_owner = OWN_NONE;
          end
          else if (phase_ms >= TURN_OFF_DEBOUNCE_MS + TURN_OFF_DEBOUNCE_MS)
          begin
            // interrupt held at least 32 ms after it went low; host still owns shutdown
            next_int_low = 1'b0;
            next_state = ST_ON;
            next_owner = OWN_NONE;
          end
        end
      end
      default:
      begin
        next_state = ST_OFF;
        next_en_on = 1'b0;
        next_int_low = 1'b0;
      end
    endcase
  end

  // interrupt width is measured from the 32 ms debounce point; the release
  // check above uses phase >= 64 ms, which gives at least 32 ms of low time

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state <= ST_OFF;
      owner <= OWN_NONE;
      deb_ms <= '0;
      phase_ms <= '0;
      en_on <= 1'b0;
      int_low <= 1'b0;
    end
    else
    begin
      state <= next_state;
      owner <= next_owner;
      deb_ms <= next_deb_ms;
      phase_ms <= next_phase_ms;
      en_on <= next_en_on;
      int_low <= next_int_low;
    end
  end

  // output registers
  logic next_power_enable;
  logic next_interrupt_n;
  logic next_warn_oe;

  always_comb
  begin
    next_power_enable = ENABLE_ACTIVE_HIGH ? next_en_on : ~next_en_on;
    next_interrupt_n = ~next_int_low;
    next_warn_oe = warn_low;
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_power_enable <= ~ENABLE_ACTIVE_HIGH;
      o_interrupt_n <= 1'b1;
      o_supply_warn_out_n <= 1'b0;
      o_supply_warn_out_oe <= 1'b0;
    end
    else
    begin
      o_power_enable <= next_power_enable;
      o_interrupt_n <= next_interrupt_n;
      o_supply_warn_out_n <= 1'b0;
      o_supply_warn_out_oe <= next_warn_oe;
    end
  end
endmodule

// ---- test/host_model.sv ----
// Purpose: host side of the keep-alive handshake
// Assumes: enable active high
// Notes: mode 0 silent, 1 full host, 2 ignores the interrupt
`timescale 1ns/100ps
module host_model
#(
  parameter int unsigned TICK_LEN = 10000
)
(
  input wire logic i_mclk,
  input wire logic i_power_enable,
  input wire logic i_interrupt_n,
  input wire logic [1:0] i_mode,
  output logic o_keep_alive
);
  int unsigned up_cnt = 0;
  initial o_keep_alive = 1'b0;
  always @(posedge i_mclk)
  begin
    up_cnt <= (i_power_enable && i_mode != 2'h0) ? up_cnt + 1 : 0;
    // a slow boot of 100 ms before confirming
    if (up_cnt == 100 * TICK_LEN) o_keep_alive <= 1'b1;
    if (!i_interrupt_n && i_mode == 2'h1) o_keep_alive <= 1'b0;
    if (!i_power_enable) o_keep_alive <= 1'b0;
  end
endmodule

// ---- test/pbc_monitor.sv ----
// Purpose: timing checks on the controller ports
// Assumes: 1 ms is TICK_LEN cycles, tick phase slack of 1 ms
// Notes: counters saturate so long holds never wrap
`timescale 1ns/100ps
module pbc_monitor
  import pbc_pkg::*;
#(
  parameter logic [MS_W-1:0] POWER_DOWN_EXTRA_DELAY = FORCED_OFF_EXTRA_MS_DEF,
  parameter bit ENABLE_ACTIVE_HIGH = 1'b1,
  parameter int unsigned TICK_LEN = TICK_CYCLES
)
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_push_button_n,
  input wire logic i_undervoltage_lockout,
  input wire logic i_supply_warn_in,
  input wire logic i_keep_alive,
  input wire logic o_power_enable,
  input wire logic o_interrupt_n,
  input wire logic o_supply_warn_out_n,
  input wire logic o_supply_warn_out_oe
);
  localparam int MS = int'(TICK_LEN);
  localparam int F = int'(FORCED_OFF_BASE_MS + POWER_DOWN_EXTRA_DELAY) * MS;
  logic en;
  logic [22:0] on_cnt, pb_lo, uv_lo, int_lo;
  assign en = (o_power_enable == ENABLE_ACTIVE_HIGH);
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      on_cnt <= '0;
      pb_lo <= '0;
      uv_lo <= '0;
      int_lo <= '0;
    end
    else
    begin
      on_cnt <= en ? on_cnt + 23'(~&on_cnt) : '0;
      pb_lo <= i_push_button_n ? '0 : pb_lo + 23'(~&pb_lo);
      uv_lo <= i_undervoltage_lockout ? '0 : uv_lo + 23'(~&uv_lo);
      int_lo <= o_interrupt_n ? '0 : int_lo + 23'(~&int_lo);
    end
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  AST_TURN_ON: assert property ($rose(en) |-> pb_lo >= 31 * MS)
    else $error("enable rose without a full button hold");
  AST_LOCKOUT: assert property ($rose(en) |-> $past(i_undervoltage_lockout, 8))
    else $error("enable rose under lockout");
  AST_BLANK: assert property (en && on_cnt < 510 * MS |=> en)
    else $error("enable dropped inside blanking");
  AST_ABORT: assert property (en && on_cnt == 513 * MS |-> $past(i_keep_alive, 8))
    else $error("enable kept without keep-alive");
  AST_KILL: assert property ((en && on_cnt > 513 * MS && !i_keep_alive) [*6] |=> !en)
    else $error("keep-alive low ignored");
  AST_INT_CAUSE: assert property ($fell(o_interrupt_n) |->
    en && (pb_lo >= 31 * MS || uv_lo >= 31 * MS))
    else $error("interrupt without a 32 ms low source");
  AST_INT_WIDTH: assert property ($rose(o_interrupt_n) && en |-> int_lo >= 31 * MS)
    else $error("interrupt pulse too short");
  AST_FORCE_MIN: assert property ($fell(en) && !i_undervoltage_lockout |->
    uv_lo >= F - MS)
    else $error("forced off too early");
  AST_FORCE_MAX: assert property (en && on_cnt > uv_lo |-> uv_lo <= F + MS)
    else $error("forced off too late");
  AST_WARN: assert property (!$past(i_rst, 3) |->
    o_supply_warn_out_oe == !$past(i_supply_warn_in, 3) && !o_supply_warn_out_n)
    else $error("warning output wrong");
endmodule
bind pbc_ctrl pbc_monitor #(.POWER_DOWN_EXTRA_DELAY(POWER_DOWN_EXTRA_DELAY),
  .ENABLE_ACTIVE_HIGH(ENABLE_ACTIVE_HIGH), .TICK_LEN(TICK_LEN))
  i_mon (.i_mclk(i_mclk), .i_rst(i_rst),
  .i_push_button_n(i_push_button_n), .i_undervoltage_lockout(i_undervoltage_lockout),
  .i_supply_warn_in(i_supply_warn_in), .i_keep_alive(i_keep_alive),
  .o_power_enable(o_power_enable), .o_interrupt_n(o_interrupt_n),
  .o_supply_warn_out_n(o_supply_warn_out_n), .o_supply_warn_out_oe(o_supply_warn_out_oe));

// ---- test/testbench.sv ----
// Purpose: scenario bench for the controller
// Assumes: default extra delay, active-high enable
// Notes: a shortened ms tick keeps the whole run near 41000 cycles
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0, rst = 1'b1, pb_n = 1'b1, uv = 1'b1, warn = 1'b1;
  logic ka, en, int_n, wn, woe;
  logic [1:0] mode = 2'h0;
  int err_count = 0, comparisons = 0;
  localparam int MS = 20;
  pbc_ctrl #(.TICK_LEN(MS)) i_dut (.i_mclk(clk), .i_rst(rst), .i_push_button_n(pb_n),
    .i_undervoltage_lockout(uv), .i_supply_warn_in(warn), .i_keep_alive(ka),
    .o_power_enable(en), .o_interrupt_n(int_n), .o_supply_warn_out_n(wn),
    .o_supply_warn_out_oe(woe));
  host_model #(.TICK_LEN(MS)) i_host (.i_mclk(clk), .i_power_enable(en), .i_interrupt_n(int_n),
    .i_mode(mode), .o_keep_alive(ka));
  initial forever #50 clk = ~clk;
  task automatic check(string what, logic got, logic exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s exp %b got %b", what, exp, got);
    end
  endtask
  task automatic ms(int n);
    repeat (n * MS) @(posedge clk);
  endtask
  task automatic press(int n);
    pb_n <= 1'b0;
    ms(n);
    pb_n <= 1'b1;
    ms(1);
  endtask
  task automatic test_done();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic t_lockout();
    uv <= 1'b0;
    press(40);
    check("en lockout", en, 1'b0);
    uv <= 1'b1;
    ms(1);
    press(20);
    press(20);
    check("en broken hold", en, 1'b0);
  endtask
  task automatic t_abort();
    mode <= 2'h0;
    press(40);
    check("en on", en, 1'b1);
    ms(400);
    check("en blank", en, 1'b1);
    ms(120);
    check("en abort", en, 1'b0);
  endtask
  task automatic t_host_off();
    mode <= 2'h1;
    press(40);
    ms(600);
    check("en kept", en, 1'b1);
    pb_n <= 1'b0;
    ms(36);
    // host drops keep-alive at once, so power is already gone
    check("en host off", en, 1'b0);
    pb_n <= 1'b1;
    ms(5);
    check("en stays off", en, 1'b0);
  endtask
  task automatic t_forced();
    mode <= 2'h2;
    press(40);
    ms(600);
    uv <= 1'b0;
    ms(36);
    check("int uv", int_n, 1'b0);
    ms(20);
    check("en before force", en, 1'b1);
    ms(12);
    check("en forced", en, 1'b0);
    check("int freed", int_n, 1'b1);
    uv <= 1'b1;
  endtask
  task automatic t_warn();
    warn <= 1'b0;
    repeat (5) @(posedge clk);
    check("warn oe", woe, 1'b1);
    warn <= 1'b1;
    repeat (5) @(posedge clk);
    check("warn oe off", woe, 1'b0);
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    ms(1);
    t_warn();
    t_lockout();
    t_abort();
    t_host_off();
    t_forced();
    test_done();
  end
  initial
  begin
    ms(2500);
    err_count++;
    test_done();
  end
endmodule
